// ---- src/zoc_pkg.sv ----
// zone control package: register map, fields, codes and carrier types
package zoc_pkg;
  localparam int ZOC_MAX_DEPTH = 8;
  localparam int ZOC_DEPTH_W = 4;
  localparam int ZOC_EV_W = 3;

  localparam logic [7:0] ZOC_ADDR_CTRL = 8'h00;
  localparam logic [7:0] ZOC_ADDR_STATUS = 8'h04;
  localparam logic [7:0] ZOC_ADDR_MASK = 8'h08;
  localparam logic [7:0] ZOC_ADDR_DEPTH = 8'h0C;
  localparam logic [7:0] ZOC_ADDR_SCANS = 8'h10;

  localparam int ZOC_CTRL_NEST_BIT = 0;
  localparam int ZOC_CTRL_FCLR_BIT = 1;
  localparam logic [31:0] ZOC_CTRL_RESET = 32'h0000_0001;
  localparam logic [31:0] ZOC_MASK_RESET = 32'h0000_0000;

  localparam int ZOC_EV_DEEP = 0;
  localparam int ZOC_EV_UNMATCHED = 1;
  localparam int ZOC_EV_SCAN = 2;

  localparam int ZOC_DEPTH_LSB = 0;
  localparam int ZOC_MAXD_LSB = 4;
  localparam int ZOC_FAULT_LSB = 8;
  localparam int ZOC_FACT_BIT = 24;

  // processor fault code 27-5
  localparam logic [7:0] ZOC_FAULT_MAJOR = 8'h1B;
  localparam logic [7:0] ZOC_FAULT_MINOR = 8'h05;

  typedef enum logic [3:0] {
    ZOC_OP_NOP,
    ZOC_OP_SCAN_BEGIN,
    ZOC_OP_SCAN_END,
    ZOC_OP_ZONE_START,
    ZOC_OP_ZONE_END,
    ZOC_OP_OUT_NONRET,
    ZOC_OP_RETENTIVE,
    ZOC_OP_EXEMPT_TIMER,
    ZOC_OP_SEQUENCER,
    ZOC_OP_SHIFT
  } zoc_op_e;

  typedef enum logic {
    ZOC_KIND_MASTER_RESET,
    ZOC_KIND_LAST_STATE
  } zoc_kind_e;

  typedef enum logic [1:0] {
    ZOC_ACT_EXECUTE,
    ZOC_ACT_DEENERGIZE,
    ZOC_ACT_HOLD
  } zoc_action_e;

  typedef struct packed {
    logic valid;
    zoc_op_e op;
    zoc_kind_e kind;
    logic cond;
  } zoc_inst_s;

  typedef struct packed {
    logic valid;
    zoc_op_e op;
    zoc_action_e action;
  } zoc_gate_s;

  typedef struct packed {
    logic eff;
    logic mcrOff;
    logic zclBlk;
  } zoc_level_s;
endpackage

// ---- src/zoc_zone_control.sv ----
// zone control gating for the ladder scan, with apb registers and irq
`timescale 1ns/100ps
module zoc_zone_control (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // instruction stream from the scan engine
  input wire zoc_pkg::zoc_inst_s inst,
  // gating verdict, one cycle after the instruction
  output zoc_pkg::zoc_gate_s gate,
  // processor fault
  output logic faultActive,
  output logic [15:0] faultCode,
  // interrupt
  output logic irq
);

  localparam logic [zoc_pkg::ZOC_DEPTH_W-1:0] MAX_D =
    zoc_pkg::ZOC_DEPTH_W'(zoc_pkg::ZOC_MAX_DEPTH);

  // one entry per open zone, innermost at depth minus one
  zoc_pkg::zoc_level_s stack [zoc_pkg::ZOC_MAX_DEPTH];
  zoc_pkg::zoc_level_s top;
  zoc_pkg::zoc_level_s next_level;
  logic [zoc_pkg::ZOC_DEPTH_W-1:0] depth;
  logic [zoc_pkg::ZOC_DEPTH_W-1:0] maxDepth;
  logic [31:0] ctrl;
  logic [zoc_pkg::ZOC_EV_W-1:0] status;
  logic [zoc_pkg::ZOC_EV_W-1:0] mask;
  logic [zoc_pkg::ZOC_EV_W-1:0] events;
  logic [31:0] scanCount;
  logic tooDeep;
  logic unmatched;
  logic wrDone;
  logic setup;
  logic mapped;
  logic [31:0] rdValue;

  // verdict for one instruction given the innermost level
  function automatic zoc_pkg::zoc_action_e classify(
    input zoc_pkg::zoc_op_e op,
    input zoc_pkg::zoc_level_s lvl,
    input logic faulted
  );
    zoc_pkg::zoc_action_e act;
    act = zoc_pkg::ZOC_ACT_EXECUTE;
    // a fault freezes every class until software clears it
    if (faulted) begin
      act = zoc_pkg::ZOC_ACT_HOLD;
    end else if (!lvl.eff) begin
      unique case (op)
        zoc_pkg::ZOC_OP_OUT_NONRET: begin
          act = lvl.mcrOff ? zoc_pkg::ZOC_ACT_DEENERGIZE
                           : zoc_pkg::ZOC_ACT_HOLD;
        end
        zoc_pkg::ZOC_OP_RETENTIVE: begin
          act = zoc_pkg::ZOC_ACT_HOLD;
        end
        // only a false last-state level stops it
        zoc_pkg::ZOC_OP_EXEMPT_TIMER: begin
          act = lvl.zclBlk ? zoc_pkg::ZOC_ACT_HOLD
                           : zoc_pkg::ZOC_ACT_EXECUTE;
        end
        zoc_pkg::ZOC_OP_SEQUENCER: begin
          act = zoc_pkg::ZOC_ACT_HOLD;
        end
        zoc_pkg::ZOC_OP_SHIFT: begin
          act = zoc_pkg::ZOC_ACT_HOLD;
        end
        default: begin
          act = zoc_pkg::ZOC_ACT_EXECUTE;
        end
      endcase
    end
    return act;
  endfunction

  // innermost level; outside any zone all is enabled
  always_comb begin
    if (depth == '0) begin
      top = '{eff: 1'b1, mcrOff: 1'b0, zclBlk: 1'b0};
    end else begin
      top = stack[3'(depth - 4'd1)];
    end
  end

  // inner level effective only if all outer are true
  always_comb begin
    next_level.eff = top.eff & inst.cond;
    // a false outer level turns inner master-reset into hold
    next_level.mcrOff = top.eff & ~inst.cond &
      (inst.kind == zoc_pkg::ZOC_KIND_MASTER_RESET);
    next_level.zclBlk = top.zclBlk | (~inst.cond &
      (inst.kind == zoc_pkg::ZOC_KIND_LAST_STATE));
  end

  // depth limit; without nesting one level only
  always_comb begin
    tooDeep = 1'b0;
    unmatched = 1'b0;
    if (inst.valid) begin
      if (inst.op == zoc_pkg::ZOC_OP_ZONE_START) begin
        if (ctrl[zoc_pkg::ZOC_CTRL_NEST_BIT]) begin
          tooDeep = (depth == MAX_D);
        end else begin
          tooDeep = (depth != '0);
        end
      end
      // end without start, or start left open at scan end
      if (inst.op == zoc_pkg::ZOC_OP_ZONE_END) begin
        unmatched = (depth == '0);
      end
      if (inst.op == zoc_pkg::ZOC_OP_SCAN_END) begin
        unmatched = (depth != '0);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      depth <= '0;
    end else if (inst.valid) begin
      unique case (inst.op)
        // a new scan drops any zone left open by a faulted scan
        zoc_pkg::ZOC_OP_SCAN_BEGIN: begin
          depth <= '0;
        end
        zoc_pkg::ZOC_OP_SCAN_END: begin
          depth <= '0;
        end
        zoc_pkg::ZOC_OP_ZONE_START: begin
          if (!tooDeep) begin
            depth <= depth + 4'd1;
          end
        end
        zoc_pkg::ZOC_OP_ZONE_END: begin
          // a stray end at depth zero faults instead of wrapping
          if (depth != '0) begin
            depth <= depth - 4'd1;
          end
        end
        default: begin
          depth <= depth;
        end
      endcase
    end
  end

  // level contents; stale entries above depth are unused
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      for (int i = 0; i < zoc_pkg::ZOC_MAX_DEPTH; i++) begin
        stack[i] <= '0;
      end
    end else if (inst.valid && inst.op == zoc_pkg::ZOC_OP_ZONE_START &&
                 !tooDeep) begin
      stack[3'(depth)] <= next_level;
    end
  end

  // deepest nesting seen in the current scan, for software
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      maxDepth <= '0;
    end else if (inst.valid && inst.op == zoc_pkg::ZOC_OP_SCAN_BEGIN) begin
      maxDepth <= '0;
    end else if (depth > maxDepth) begin
      maxDepth <= depth;
    end
  end

  // true or no zone and no fault: every writer executes in order
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      gate <= '{valid: 1'b0, op: zoc_pkg::ZOC_OP_NOP,
                action: zoc_pkg::ZOC_ACT_EXECUTE};
    end else begin
      gate.valid <= inst.valid;
      gate.op <= inst.op;
      gate.action <= classify(inst.op, top,
                              faultActive | tooDeep | unmatched);
    end
  end

  // fault latches until software clears it; set wins
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      faultActive <= 1'b0;
    end else if (tooDeep || unmatched) begin
      faultActive <= 1'b1;
    end else if (wrDone && paddr == zoc_pkg::ZOC_ADDR_CTRL &&
                 pwdata[zoc_pkg::ZOC_CTRL_FCLR_BIT]) begin
      faultActive <= 1'b0;
    end
  end

  // cause kept after a clear so software can still read it
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      faultCode <= 16'h0000;
    end else if (tooDeep || unmatched) begin
      faultCode <= {zoc_pkg::ZOC_FAULT_MAJOR, zoc_pkg::ZOC_FAULT_MINOR};
    end
  end

  // free-running scan tally; wraps to zero after all ones
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      scanCount <= 32'h0000_0000;
    end else if (inst.valid && inst.op == zoc_pkg::ZOC_OP_SCAN_END) begin
      scanCount <= scanCount + 32'h0000_0001;
    end
  end

  // one-cycle event pulses feeding the sticky status bits
  always_comb begin
    events = '0;
    events[zoc_pkg::ZOC_EV_DEEP] = tooDeep;
    events[zoc_pkg::ZOC_EV_UNMATCHED] = unmatched;
    events[zoc_pkg::ZOC_EV_SCAN] = inst.valid &&
      (inst.op == zoc_pkg::ZOC_OP_SCAN_END);
  end

  // apb: answer registered, so pready rises in the first access cycle
  assign setup = psel & ~penable;
  assign wrDone = psel & penable & pready & pwrite;

  // unmapped offsets answer with an error and read zero
  always_comb begin
    mapped = 1'b1;
    rdValue = 32'h0000_0000;
    unique case (paddr)
      zoc_pkg::ZOC_ADDR_CTRL: begin
        rdValue[zoc_pkg::ZOC_CTRL_NEST_BIT] =
          ctrl[zoc_pkg::ZOC_CTRL_NEST_BIT];
      end
      zoc_pkg::ZOC_ADDR_STATUS: begin
        rdValue[zoc_pkg::ZOC_EV_W-1:0] = status;
      end
      zoc_pkg::ZOC_ADDR_MASK: begin
        rdValue[zoc_pkg::ZOC_EV_W-1:0] = mask;
      end
      zoc_pkg::ZOC_ADDR_DEPTH: begin
        rdValue[zoc_pkg::ZOC_DEPTH_LSB +: 4] = depth;
        rdValue[zoc_pkg::ZOC_MAXD_LSB +: 4] = maxDepth;
        rdValue[zoc_pkg::ZOC_FAULT_LSB +: 16] = faultCode;
        rdValue[zoc_pkg::ZOC_FACT_BIT] = faultActive;
      end
      zoc_pkg::ZOC_ADDR_SCANS: begin
        rdValue = scanCount;
      end
      default: begin
        mapped = 1'b0;
      end
    endcase
  end

  // read data taken at setup, so no wait state is ever needed
  // limitation: a value moving during the access shows its old state
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= setup;
      pslverr <= setup & ~mapped;
      if (setup && !pwrite) begin
        prdata <= rdValue;
      end
    end
  end

  // only the nest bit is stored; the fault clear bit is a strobe
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      ctrl <= zoc_pkg::ZOC_CTRL_RESET;
      mask <= zoc_pkg::ZOC_MASK_RESET[zoc_pkg::ZOC_EV_W-1:0];
    end else if (wrDone) begin
      if (paddr == zoc_pkg::ZOC_ADDR_CTRL) begin
        ctrl[zoc_pkg::ZOC_CTRL_NEST_BIT] <=
          pwdata[zoc_pkg::ZOC_CTRL_NEST_BIT];
      end
      if (paddr == zoc_pkg::ZOC_ADDR_MASK) begin
        mask <= pwdata[zoc_pkg::ZOC_EV_W-1:0];
      end
    end
  end

  // write one to clear; a new event in the same cycle survives
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      status <= '0;
    end else if (wrDone && paddr == zoc_pkg::ZOC_ADDR_STATUS) begin
      status <= (status & ~pwdata[zoc_pkg::ZOC_EV_W-1:0]) | events;
    end else begin
      status <= status | events;
    end
  end

  // registered pin: glitch free, but one cycle behind status
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(status & mask);
    end
  end

endmodule

// ---- verif/zoc_assertions.sv ----
// port assertions for the zone control block
`timescale 1ns/100ps
module zoc_checker (
  // clock and reset
  input logic clk,
  input logic reset_n,
  // register bus
  input logic psel,
  input logic penable,
  input logic pwrite,
  input logic [7:0] paddr,
  input logic [31:0] pwdata,
  // scan side
  input zoc_pkg::zoc_inst_s inst,
  input zoc_pkg::zoc_gate_s gate,
  input logic faultActive,
  input logic [15:0] faultCode
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  wire hold = gate.action == zoc_pkg::ZOC_ACT_HOLD;
  wire exec = gate.action == zoc_pkg::ZOC_ACT_EXECUTE;
  wire start = inst.valid && inst.op == zoc_pkg::ZOC_OP_ZONE_START;
  // a clear strobe in the same cycle does not release the hold; the verdict uses the old faultActive
  wire clr = psel && penable && pwrite && paddr == zoc_pkg::ZOC_ADDR_CTRL
    && pwdata[zoc_pkg::ZOC_CTRL_FCLR_BIT];
  sequence s_op(o);
    inst.valid && inst.op == o;
  endsequence
  sequence s_open(k, c);
    start && inst.kind == k && inst.cond == c;
  endsequence
  sequence s_false;
    start && !inst.cond;
  endsequence
  property p_code;
    faultActive |-> faultCode == {zoc_pkg::ZOC_FAULT_MAJOR,
      zoc_pkg::ZOC_FAULT_MINOR};
  endproperty
  a_code: assert property (p_code)
    else $error("fault code wrong");
  property p_fhold;
    faultActive && inst.valid && !clr |=> hold;
  endproperty
  a_fhold: assert property (p_fhold)
    else $error("faulted instruction not held");
  property p_unmatched;
    start ##1 s_op(zoc_pkg::ZOC_OP_SCAN_END) |=> faultActive && hold;
  endproperty
  a_unmatched: assert property (p_unmatched)
    else $error("open zone at scan end not faulted");
  property p_frozen;
    s_false ##1 (inst.valid && inst.op inside {zoc_pkg::ZOC_OP_RETENTIVE,
      zoc_pkg::ZOC_OP_SEQUENCER, zoc_pkg::ZOC_OP_SHIFT}) |=> hold;
  endproperty
  a_frozen: assert property (p_frozen)
    else $error("retentive op not frozen");
  property p_mr_out;
    s_open(zoc_pkg::ZOC_KIND_MASTER_RESET, 1'b0)
      ##1 s_op(zoc_pkg::ZOC_OP_OUT_NONRET) |=> !exec;
  endproperty
  a_mr_out: assert property (p_mr_out)
    else $error("output executed in false zone");
  property p_ls_out;
    s_open(zoc_pkg::ZOC_KIND_LAST_STATE, 1'b0)
      ##1 s_op(zoc_pkg::ZOC_OP_OUT_NONRET) |=> hold;
  endproperty
  a_ls_out: assert property (p_ls_out)
    else $error("output not held in false zone");
  property p_nested;
    s_false ##1 s_open(zoc_pkg::ZOC_KIND_LAST_STATE, 1'b1)
      ##1 s_op(zoc_pkg::ZOC_OP_OUT_NONRET) |=> hold;
  endproperty
  a_nested: assert property (p_nested)
    else $error("inner output not held");
  property p_empty;
    s_false ##1 (inst.valid && inst.op == zoc_pkg::ZOC_OP_ZONE_END
      && !faultActive) |=> exec;
  endproperty
  a_empty: assert property (p_empty)
    else $error("zone end not executed");
endmodule

bind zoc_zone_control zoc_checker u_chk (.clk, .reset_n, .psel, .penable,
  .pwrite, .paddr, .pwdata, .inst, .gate, .faultActive, .faultCode);

// ---- verif/zoc_testbench.sv ----
// self-checking bench for the zone control block
`timescale 1ns/100ps
module testbench;
  localparam zoc_pkg::zoc_op_e SB = zoc_pkg::ZOC_OP_SCAN_BEGIN;
  localparam zoc_pkg::zoc_op_e SE = zoc_pkg::ZOC_OP_SCAN_END;
  localparam zoc_pkg::zoc_op_e ZS = zoc_pkg::ZOC_OP_ZONE_START;
  localparam zoc_pkg::zoc_op_e ZE = zoc_pkg::ZOC_OP_ZONE_END;
  localparam zoc_pkg::zoc_op_e ON = zoc_pkg::ZOC_OP_OUT_NONRET;
  localparam zoc_pkg::zoc_op_e RT = zoc_pkg::ZOC_OP_RETENTIVE;
  localparam zoc_pkg::zoc_op_e ET = zoc_pkg::ZOC_OP_EXEMPT_TIMER;
  localparam zoc_pkg::zoc_op_e SQ = zoc_pkg::ZOC_OP_SEQUENCER;
  localparam zoc_pkg::zoc_op_e SH = zoc_pkg::ZOC_OP_SHIFT;
  localparam logic [1:0] EX = zoc_pkg::ZOC_ACT_EXECUTE;
  localparam logic [1:0] DE = zoc_pkg::ZOC_ACT_DEENERGIZE;
  localparam logic [1:0] HO = zoc_pkg::ZOC_ACT_HOLD;
  localparam logic [7:0] CTL = zoc_pkg::ZOC_ADDR_CTRL;
  localparam logic [7:0] STA = zoc_pkg::ZOC_ADDR_STATUS;
  localparam logic [7:0] MSK = zoc_pkg::ZOC_ADDR_MASK;
  logic clk = 0;
  logic reset_n = 0;
  logic psel = 0;
  logic penable = 0;
  logic pwrite = 0;
  logic [7:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata;
  logic [31:0] m;
  logic pready, pslverr, faultActive, irq;
  logic [15:0] faultCode;
  zoc_pkg::zoc_inst_s inst = '0;
  zoc_pkg::zoc_gate_s gate;
  int n_errors = 0;
  int n_tests = 0;
  logic [5:0] qAct[$];
  logic [32:0] qRd[$];

  always #25 clk = ~clk;

  zoc_zone_control DUT (.clk, .reset_n, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .inst, .gate, .faultActive,
    .faultCode, .irq);

  task automatic chk(input string what, input logic [32:0] e, g);
    n_tests++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic stop_test();
    if (n_errors == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // one transfer, then an idle cycle so requests never collide
  task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d, input logic [32:0] e = '0);
    int k;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    if (!w)
      qRd.push_back(e);
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (pready !== 1'b1) begin
      n_errors++;
      stop_test();
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic z(input zoc_pkg::zoc_op_e op, input logic k, c,
      input logic [1:0] a);
    inst <= '{1'b1, op, zoc_pkg::zoc_kind_e'(k), c};
    qAct.push_back({op, a});
    @(posedge clk);
  endtask

  task automatic idle();
    inst <= '0;
    repeat (2) @(posedge clk);
  endtask

  always @(posedge clk) begin
    if (gate.valid === 1'b1)
      chk("gate", qAct.size() ? qAct.pop_front() : 'x,
        {gate.op, gate.action});
    if (psel && penable && pready === 1'b1 && !pwrite)
      chk("read", qRd.size() ? qRd.pop_front() : 'x, {pslverr, prdata});
  end

  initial begin
    m = $urandom(32'hcc78b524);
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    apb(0, CTL, 0, 33'h0_0000_0001);
    apb(0, MSK, 0, 33'h0_0000_0000);
    apb(0, STA, 0, 33'h0_0000_0000);
    apb(0, zoc_pkg::ZOC_ADDR_DEPTH, 0, 33'h0_0000_0000);
    apb(0, 8'h20, 0, 33'h1_0000_0000);
    apb(1, MSK, m);
    apb(0, MSK, 0, {30'h0, m[2:0]});
    z(SB, 0, 0, EX);
    z(ON, 0, 0, EX);
    z(ZS, 0, 0, EX);
    z(RT, 0, 0, HO);
    z(ON, 0, 0, DE);
    z(ET, 0, 0, EX);
    z(SQ, 0, 0, HO);
    z(SH, 0, 0, HO);
    z(ZE, 0, 0, EX);
    z(ZS, 1, 1, EX);
    z(ON, 0, 0, EX);
    z(ZE, 0, 0, EX);
    z(ZS, 1, 0, EX);
    z(ON, 0, 0, HO);
    z(ZS, 1, 1, EX);
    z(ON, 0, 0, HO);
    z(ET, 0, 0, HO);
    z(ZE, 0, 0, EX);
    z(ZE, 0, 0, EX);
    z(ZS, 0, 0, EX);
    z(ZE, 0, 0, EX);
    z(SE, 0, 0, EX);
    idle();
    chk("irq", {32'h0, m[2]}, irq);
    apb(1, MSK, 32'h0000_0004);
    // irq follows a mask or status write one cycle later
    @(posedge clk);
    chk("irq", 33'h0_0000_0001, irq);
    apb(1, STA, 32'h0000_0004);
    @(posedge clk);
    chk("irq", 33'h0_0000_0000, irq);
    apb(0, STA, 0, 33'h0_0000_0000);
    z(SB, 0, 0, EX);
    repeat (8) z(ZS, 1, 1, EX);
    z(ON, 0, 0, EX);
    z(ZS, 1, 1, HO);
    z(ON, 0, 0, HO);
    idle();
    chk("fault", 33'h0_0001_1B05, {faultActive, faultCode});
    apb(0, zoc_pkg::ZOC_ADDR_DEPTH, 0, 33'h0_011B_0588);
    apb(0, STA, 0, 33'h0_0000_0001);
    apb(1, CTL, 32'h0000_0003);
    repeat (8) z(ZE, 0, 0, EX);
    z(SE, 0, 0, EX);
    idle();
    apb(1, STA, 32'h0000_0007);
    z(ZE, 0, 0, HO);
    idle();
    apb(0, STA, 0, 33'h0_0000_0002);
    apb(0, zoc_pkg::ZOC_ADDR_SCANS, 0, 33'h0_0000_0002);
    apb(1, CTL, 32'h0000_0002);
    z(SB, 0, 0, EX);
    z(ZS, 1, 1, EX);
    z(ZS, 1, 1, HO);
    z(SE, 0, 0, HO);
    idle();
    if (qAct.size() + qRd.size() != 0)
      n_errors++;
    stop_test();
  end
endmodule
